// *** src/rotl_pkg.sv ***
// constants for the reset-time option, protection and trim loader
package rotl_pkg;
  // flash array addresses of the reserved store bytes
  localparam logic [15:0] FINE_TRIM_STORE_ADDR   = 16'hffae;
  localparam logic [15:0] COARSE_TRIM_STORE_ADDR = 16'hffaf;
  localparam logic [15:0] BACKDOOR_KEY_ADDR      = 16'hffb0;
  localparam logic [15:0] BLOCK_PROTECT_ST_ADDR  = 16'hffbd;
  localparam logic [15:0] SECURITY_OPT_ST_ADDR   = 16'hffbf;
  // hidden information row locations of the factory trim
  localparam logic [15:0] ROW_COARSE_TRIM_ADDR   = 16'h0000;
  localparam logic [15:0] ROW_FINE_TRIM_ADDR     = 16'h0001;
  localparam logic [2:0]  KEY_LAST_IDX           = 3'h7;

  // register indices; byte address is four times the index
  localparam logic [13:0] SECURITY_OPT_IDX       = 14'h1821;
  localparam logic [13:0] BLK_PROT_WORKING_IDX   = 14'h1824;
  localparam logic [13:0] TRIM_CTRL_IDX          = 14'h1828;
  localparam logic [13:0] LOADER_STATUS_IDX      = 14'h1829;
  localparam logic [13:0] KEY_ENTRY_LO_IDX       = 14'h182a;
  localparam logic [13:0] KEY_ENTRY_HI_IDX       = 14'h182b;
  localparam logic [13:0] KEY_COMMAND_IDX        = 14'h182c;

  // field positions and patterns
  localparam int          KEY_ENABLE_BIT         = 7;
  localparam int          VECTOR_REDIRECT_BIT    = 6;
  localparam int          FINE_TRIM_BIT          = 0;
  localparam int          TRIM_FINE_FIELD_BIT    = 8;
  localparam int          KEY_COMPARE_BIT        = 0;
  localparam logic [1:0]  UNSECURED_PATTERN      = 2'h2;

  // reset values
  localparam logic [7:0]  COARSE_TRIM_RESET      = 8'h80;
  localparam logic        FINE_TRIM_RESET        = 1'h0;
  localparam logic [7:0]  SECURITY_OPT_RESET     = 8'h00;
  localparam logic [7:0]  BLK_PROT_RESET         = 8'h00;

  // loader sequence
  typedef enum logic [2:0] {
    LD_PROT = 3'h0,
    LD_OPT  = 3'h1,
    LD_KEY  = 3'h2,
    LD_TRC  = 3'h3,
    LD_TRF  = 3'h4,
    LD_DONE = 3'h5
  } rotl_state_t;
endpackage

// *** src/rotl_rd_if.sv ***
// read request channel between the loader and its flash reader
`timescale 1ns/10ps
interface rotl_rd_if;
  logic        req;
  logic [15:0] addr;
  logic        row;
  logic        done;
  logic [7:0]  data;

  modport requester (output req, output addr, output row,
                     input done, input data);
  modport responder (input req, input addr, input row,
                     output done, output data);
endinterface

// *** src/rotl_flash_rd.sv ***
// single-byte flash read engine, one request outstanding
`timescale 1ns/10ps
module rotl_flash_rd (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  rotl_rd_if.responder    rd,
  output logic [15:0]     flash_addr_o,
  output logic            flash_rd_o,
  output logic            flash_row_o,
  input  wire logic [7:0] flash_data_i,
  input  wire logic       flash_valid_i
);
  // hold strobe and address until the array answers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_rd_o   <= 1'b0;
      flash_addr_o <= 16'h0000;
      flash_row_o  <= 1'b0;
      rd.done      <= 1'b0;
      rd.data      <= 8'h00;
    end else begin
      rd.done <= 1'b0;
      if (!flash_rd_o && rd.req) begin
        flash_rd_o   <= 1'b1;
        flash_addr_o <= rd.addr;
        flash_row_o  <= rd.row;
      end else if (flash_rd_o && flash_valid_i) begin
        flash_rd_o  <= 1'b0;
        flash_row_o <= 1'b0; // row select never outlives the read
        rd.done     <= 1'b1;
        rd.data     <= flash_data_i;
      end
    end
  end
endmodule

// *** src/rotl_top.sv ***
// reset-time loader for security, protection and clock trim settings
//
// Contract
// - every reset copies protection and option bytes
// - reset loads factory trim from hidden row
// - debug mode at reset skips factory trim
// - debug mode: coarse trim 0x80, fine 0
// - hidden row usable only by the loader
// - eight-byte key match unlocks secured resources
// - byte 0xffaf holds user coarse trim copy
// - key honoured only while key enable set
// - only pattern 1:0 means unsecured
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
module rotl_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        dbg_active_i,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // flash array read port
  output logic [15:0]      flash_addr_o,
  output logic             flash_rd_o,
  output logic             flash_row_o,
  input  wire logic [7:0]  flash_data_i,
  input  wire logic        flash_valid_i,
  // settings handed to the rest of the chip
  output logic             cpu_run_o,
  output logic             secured_o,
  output logic [7:0]       block_protect_o,
  output logic [7:0]       security_option_o,
  output logic [7:0]       coarse_trim_o,
  output logic             fine_trim_o
);
  rotl_rd_if rd ();

  rotl_pkg::rotl_state_t state_reg;
  logic [2:0]  key_idx_reg;
  logic        pend_reg;
  logic        first_reg;
  logic        dbg_lat_reg;
  logic        unlock_reg;
  logic [7:0]  key_store_reg [0:7];
  logic [63:0] key_entry_reg;
  logic [7:0]  key_match;
  logic [13:0] idx;
  logic        wr_en;
  logic        bus_hit;
  logic        key_cmd;
  logic [15:0] addr_next;
  logic        row_next;

  rotl_flash_rd u_rd (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .rd            (rd.responder),
    .flash_addr_o  (flash_addr_o),
    .flash_rd_o    (flash_rd_o),
    .flash_row_o   (flash_row_o),
    .flash_data_i  (flash_data_i),
    .flash_valid_i (flash_valid_i)
  );

  // debug mode is caught once, in the first cycle after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_reg   <= 1'b1;
      dbg_lat_reg <= 1'b0;
    end else if (first_reg) begin
      first_reg   <= 1'b0;
      dbg_lat_reg <= dbg_active_i;
    end
  end

  // loader sequence, advanced by each finished read except in LD_KEY, which it leaves only after the eighth
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= rotl_pkg::LD_PROT;
    end else if (rd.done) begin
      case (state_reg)
        rotl_pkg::LD_PROT: state_reg <= rotl_pkg::LD_OPT;
        rotl_pkg::LD_OPT:  state_reg <= rotl_pkg::LD_KEY;
        rotl_pkg::LD_KEY: begin
          if (key_idx_reg == rotl_pkg::KEY_LAST_IDX) begin
            // factory row left untouched in debug mode
            state_reg <= dbg_lat_reg ? rotl_pkg::LD_DONE
                                     : rotl_pkg::LD_TRC;
          end
        end
        rotl_pkg::LD_TRC:  state_reg <= rotl_pkg::LD_TRF;
        rotl_pkg::LD_TRF:  state_reg <= rotl_pkg::LD_DONE;
        default:           state_reg <= rotl_pkg::LD_DONE;
      endcase
    end
  end

  // key byte counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_idx_reg <= 3'h0;
    end else if (rd.done && state_reg == rotl_pkg::LD_KEY) begin
      key_idx_reg <= key_idx_reg + 3'h1;
    end
  end

  // address of the byte the current state needs
  always_comb begin
    addr_next = rotl_pkg::BLOCK_PROTECT_ST_ADDR;
    row_next  = 1'b0;
    case (state_reg)
      rotl_pkg::LD_PROT: addr_next = rotl_pkg::BLOCK_PROTECT_ST_ADDR;
      rotl_pkg::LD_OPT:  addr_next = rotl_pkg::SECURITY_OPT_ST_ADDR;
      rotl_pkg::LD_KEY:
        addr_next = rotl_pkg::BACKDOOR_KEY_ADDR + {13'h0, key_idx_reg};
      rotl_pkg::LD_TRC: begin
        addr_next = rotl_pkg::ROW_COARSE_TRIM_ADDR;
        row_next  = 1'b1;
      end
      rotl_pkg::LD_TRF: begin
        addr_next = rotl_pkg::ROW_FINE_TRIM_ADDR;
        row_next  = 1'b1;
      end
      default: begin
        addr_next = rotl_pkg::BLOCK_PROTECT_ST_ADDR;
        row_next  = 1'b0;
      end
    endcase
  end

  // one request per byte, eight in LD_KEY; the row select is only ever raised here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd.req   <= 1'b0;
      rd.addr  <= 16'h0000;
      rd.row   <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      rd.req <= 1'b0;
      if (rd.done) begin
        pend_reg <= 1'b0;
      end else if (!pend_reg && !first_reg &&
                   state_reg != rotl_pkg::LD_DONE) begin
        rd.req   <= 1'b1;
        rd.addr  <= addr_next;
        rd.row   <= row_next;
        pend_reg <= 1'b1;
      end
    end
  end

  // processor held until the last copy has landed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_run_o <= 1'b0;
    end else begin
      cpu_run_o <= (state_reg == rotl_pkg::LD_DONE);
    end
  end

  // wishbone decode; one wait state, write lands on the ack edge
  assign idx     = wb_adr_i[15:2];
  assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
  assign key_cmd = wr_en && wb_sel_i[0] &&
                   idx == rotl_pkg::KEY_COMMAND_IDX &&
                   wb_dat_i[rotl_pkg::KEY_COMPARE_BIT];

  // option byte: loader only, software sees it read-only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      security_option_o <= rotl_pkg::SECURITY_OPT_RESET;
    end else if (rd.done && state_reg == rotl_pkg::LD_OPT) begin
      security_option_o <= rd.data;
    end
  end

  // protection byte: loader first, then software may rewrite it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_protect_o <= rotl_pkg::BLK_PROT_RESET;
    end else if (rd.done && state_reg == rotl_pkg::LD_PROT) begin
      block_protect_o <= rd.data;
    end else if (wr_en && wb_sel_i[0] &&
                 idx == rotl_pkg::BLK_PROT_WORKING_IDX) begin
      block_protect_o <= wb_dat_i[7:0];
    end
  end

  // trim: factory value from the row, or defaults in debug mode;
  // user copies in flash are never fetched, software moves them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coarse_trim_o <= rotl_pkg::COARSE_TRIM_RESET;
      fine_trim_o   <= rotl_pkg::FINE_TRIM_RESET;
    end else if (rd.done && state_reg == rotl_pkg::LD_TRC) begin
      coarse_trim_o <= rd.data;
    end else if (rd.done && state_reg == rotl_pkg::LD_TRF) begin
      fine_trim_o <= rd.data[rotl_pkg::FINE_TRIM_BIT];
    end else if (wr_en && idx == rotl_pkg::TRIM_CTRL_IDX) begin
      if (wb_sel_i[0]) begin
        coarse_trim_o <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        fine_trim_o <= wb_dat_i[rotl_pkg::TRIM_FINE_FIELD_BIT];
      end
    end
  end

  // stored key bytes, indexed by the load counter
  always_ff @(posedge clk_i) begin
    if (rd.done && state_reg == rotl_pkg::LD_KEY) begin
      key_store_reg[key_idx_reg] <= rd.data;
    end
  end

  // key entry words written byte-lane by byte-lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_entry_reg <= 64'h0000000000000000;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (wr_en && wb_sel_i[b]) begin
          if (idx == rotl_pkg::KEY_ENTRY_LO_IDX) begin
            key_entry_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
          if (idx == rotl_pkg::KEY_ENTRY_HI_IDX) begin
            key_entry_reg[32 + b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
    end
  end

  // per-byte key comparison
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_match
      assign key_match[g] = (key_store_reg[g] == key_entry_reg[g*8 +: 8]);
    end
  endgenerate

  // unlock sticks until the next reset; a disabled key never opens
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_reg <= 1'b0;
    end else if (key_cmd && cpu_run_o && (&key_match) &&
                 security_option_o[rotl_pkg::KEY_ENABLE_BIT]) begin
      unlock_reg <= 1'b1;
    end
  end

  // any pattern but 1:0 keeps the part secured until a key unlock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      secured_o <= 1'b1;
    end else begin
      secured_o <= (security_option_o[1:0] !=
                    rotl_pkg::UNSECURED_PATTERN) && !unlock_reg;
    end
  end

  // bus answer; unmapped indices read zero and ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_hit;
      wb_dat_o <= 32'h00000000;
      if (bus_hit && !wb_we_i) begin
        case (idx)
          rotl_pkg::SECURITY_OPT_IDX:
            wb_dat_o <= {24'h000000, security_option_o};
          rotl_pkg::BLK_PROT_WORKING_IDX:
            wb_dat_o <= {24'h000000, block_protect_o};
          rotl_pkg::TRIM_CTRL_IDX:
            wb_dat_o <= {23'h0, fine_trim_o, coarse_trim_o};
          rotl_pkg::LOADER_STATUS_IDX:
            wb_dat_o <= {28'h0000000, dbg_lat_reg, unlock_reg,
                         secured_o, cpu_run_o};
          default:
            wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_CPU_HOLD: assert property (
    cpu_run_o |-> state_reg == rotl_pkg::LD_DONE && !pend_reg)
    else $error("processor released before loading finished");

  AST_PROT_COPY: assert property (
    rd.done && state_reg == rotl_pkg::LD_PROT
    |=> block_protect_o == $past(rd.data))
    else $error("protection byte not copied");

  AST_OPT_COPY: assert property (
    rd.done && state_reg == rotl_pkg::LD_OPT
    |=> security_option_o == $past(rd.data) ##0 !cpu_run_o)
    else $error("option byte not copied");

  AST_TRIM_LOAD: assert property (
    rd.done && state_reg == rotl_pkg::LD_TRC
    |=> coarse_trim_o == $past(rd.data) ##1 state_reg != rotl_pkg::LD_PROT)
    else $error("factory coarse trim not loaded");

  AST_DBG_SKIP: assert property (
    dbg_lat_reg |-> !flash_row_o && !rd.row)
    else $error("hidden row read in debug mode");

  AST_DBG_DEFAULT: assert property (
    $rose(cpu_run_o) && dbg_lat_reg
    |-> coarse_trim_o == 8'h80 && !fine_trim_o)
    else $error("debug mode trim defaults wrong");

  AST_ROW_PRIVATE: assert property (
    flash_row_o |-> !cpu_run_o && flash_rd_o)
    else $error("hidden row reachable outside the loader");

  AST_NO_USER_TRIM: assert property (
    flash_rd_o |-> flash_addr_o != rotl_pkg::COARSE_TRIM_STORE_ADDR &&
                   flash_addr_o != rotl_pkg::FINE_TRIM_STORE_ADDR)
    else $error("user trim copy fetched by hardware");

  AST_KEY_GRANT: assert property (
    key_cmd && cpu_run_o && (&key_match) && security_option_o[7]
    |=> unlock_reg ##1 !secured_o)
    else $error("matching key did not unlock");

  AST_KEY_GATE: assert property (
    $rose(unlock_reg) |-> $past(security_option_o[7]))
    else $error("unlock with key disabled");

  AST_SEC_DECODE: assert property (
    $past(security_option_o[1:0]) != 2'h2 && !$past(unlock_reg)
    |-> secured_o)
    else $error("unsecured without 1:0 pattern");

  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

// *** verification/rotl_flash_model.sv ***
// flash array model: reserved store bytes and hidden row, with latency
`timescale 1ns/10ps
module rotl_flash_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire logic [7:0]  prot_i,
  input  wire logic [7:0]  opt_i,
  input  wire logic [63:0] key_i,
  input  wire logic [15:0] flash_addr_i,
  input  wire logic        flash_rd_i,
  input  wire logic        flash_row_i,
  output logic [7:0]       flash_data_o,
  output logic             flash_valid_o
);
  localparam logic [7:0] ROW_COARSE = 8'h5a;
  localparam logic [7:0] ROW_FINE   = 8'h01;
  localparam logic [7:0] USER_TRIM  = 8'h27;
  logic [2:0] wait_cnt;
  logic [7:0] rd_byte;
  // byte lookup; row answers only to row-select reads
  always_comb begin
    rd_byte = 8'h00;
    if (flash_row_i) begin
      rd_byte = (flash_addr_i[0]) ? ROW_FINE : ROW_COARSE;
    end else if (flash_addr_i[15:3] == 13'h1ff6) begin
      rd_byte = key_i[8*flash_addr_i[2:0] +: 8];
    end else if (flash_addr_i == 16'hffbd) begin
      rd_byte = prot_i;
    end else if (flash_addr_i == 16'hffbf) begin
      rd_byte = opt_i;
    end else if (flash_addr_i == 16'hffaf) begin
      rd_byte = USER_TRIM;
    end
  end
  // answer one cycle after the strobe, five with slow_i; data inverted when idle so stale bytes never match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_cnt      <= 3'h0;
      flash_valid_o <= 1'b0;
      flash_data_o  <= 8'h00;
    end else if (flash_valid_o) begin
      flash_valid_o <= 1'b0;
      flash_data_o  <= ~flash_data_o;
    end else if (flash_rd_i && (wait_cnt == (slow_i ? 3'h4 : 3'h0))) begin
      flash_valid_o <= 1'b1;
      flash_data_o  <= rd_byte;
      wait_cnt      <= 3'h0;
    end else if (flash_rd_i) begin
      wait_cnt      <= wait_cnt + 3'h1;
    end
  end
endmodule

// *** verification/test_reset_option_trim_loader.sv ***
// bench: reset loads, trim, register access and key unlock
`timescale 1ns/10ps
module test_reset_option_trim_loader;
  logic        clk_i, rst_i, dbg, cyc, stb, we, slow;
  logic [15:0] adr;
  logic [31:0] dat, wb_dat_o, q;
  logic        wb_ack_o, f_rd, f_row, f_vld, run, locked;
  logic [3:0]  sel, lanes;
  logic [15:0] f_adr;
  logic [7:0]  f_dat, prot, opt, bp, so, ct;
  logic        ft;
  logic [63:0] key;
  int          miscompares, cmp_count, cyc_n;
  localparam logic [63:0] KEY = 64'h0123456789abcdef;

  rotl_top u_rotl_top (.clk_i(clk_i), .rst_i(rst_i), .dbg_active_i(dbg),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flash_addr_o(f_adr), .flash_rd_o(f_rd),
    .flash_row_o(f_row), .flash_data_i(f_dat), .flash_valid_i(f_vld),
    .cpu_run_o(run), .secured_o(locked), .block_protect_o(bp),
    .security_option_o(so), .coarse_trim_o(ct), .fine_trim_o(ft));
  rotl_flash_model u_rotl_flash_model (.clk_i(clk_i), .rst_i(rst_i),
    .slow_i(slow), .prot_i(prot), .opt_i(opt), .key_i(key),
    .flash_addr_i(f_adr), .flash_rd_i(f_rd), .flash_row_i(f_row),
    .flash_data_o(f_dat), .flash_valid_o(f_vld));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // classic single cycle; release only after ack is sampled
  task automatic wb(input logic w, input logic [13:0] idx,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    sel <= lanes;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk("ack", 1, 0);
    // a write lands at the ack edge; outputs settle one edge later
    @(posedge clk_i);
  endtask

  // reset with given store bytes, wait for loads to finish
  task automatic boot(input logic b, input logic s, input logic [7:0] p,
                      input logic [7:0] o);
    int n;
    n = 0;
    @(posedge clk_i);
    rst_i <= 1'b1;
    dbg <= b;
    slow <= s;
    prot <= p;
    opt <= o;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (run !== 1'b1 && n < 200);
    chk("cpu_run", 1, run);
    chk("block_protect", p, bp);
    chk("security_option", o, so);
  endtask

  task automatic unlock(input logic [63:0] k, input logic exp_lock);
    wb(1'b1, 14'h182a, k[31:0]);
    wb(1'b1, 14'h182b, k[63:32]);
    wb(1'b1, 14'h182c, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("secured", exp_lock, locked);
  endtask

  // hidden row only for loader, never in debug; no load after run
  always @(posedge clk_i) begin
    if (!rst_i && f_rd === 1'b1) begin
      if (f_row === 1'b1 && (dbg || f_adr > 16'h0001))
        chk("row", 0, 1);
      if (f_row === 1'b0 && f_adr[15:1] == 15'h7fd7)
        chk("user trim", 0, 1);
      if (run !== 1'b0) chk("late load", 0, 1);
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    {rst_i, dbg, cyc, stb, we, slow} = 6'h20;
    sel = 4'h0;
    lanes = 4'hf;
    adr = 16'h0000;
    dat = 32'h0;
    prot = 8'h00;
    opt = 8'h00;
    key = KEY;
    miscompares = 0;
    cmp_count = 0;
    cyc_n = 0;
    // normal boot, slow flash, unsecured pattern
    boot(1'b0, 1'b1, 8'h3c, 8'h82);
    chk("coarse", 8'h5a, ct);
    chk("fine", 1, ft);
    chk("secured", 0, locked);
    wb(1'b0, 14'h1829, 32'h0);
    chk("status", 32'h1, q);
    wb(1'b1, 14'h1821, 32'hff);
    wb(1'b0, 14'h1821, 32'h0);
    chk("option ro", 32'h82, q);
    wb(1'b1, 14'h1824, 32'ha5);
    wb(1'b0, 14'h1824, 32'h0);
    chk("protect rw", 32'ha5, q);
    wb(1'b0, 14'h1900, 32'h0);
    chk("unmapped", 0, q);
    // software copies user trim
    wb(1'b1, 14'h1828, 32'h127);
    chk("sw coarse", 8'h27, ct);
    chk("sw fine", 1, ft);
    // lane 0 only: coarse moves, fine bit in lane 1 must hold
    lanes = 4'h1;
    wb(1'b1, 14'h1828, 32'h011);
    lanes = 4'hf;
    chk("lane coarse", 8'h11, ct);
    chk("lane fine", 1, ft);
    // debug boot, prompt flash, secured, key enabled
    boot(1'b1, 1'b0, 8'h01, 8'h80);
    chk("dbg coarse", 8'h80, ct);
    chk("dbg fine", 0, ft);
    chk("secured", 1, locked);
    unlock(KEY ^ 64'h1, 1'b1);
    unlock(KEY, 1'b0);
    wb(1'b0, 14'h1829, 32'h0);
    chk("status", 32'hd, q);
    // key disabled, pattern 1:1 stays secured; then key enabled, pattern 0:1 secured
    boot(1'b0, 1'b0, 8'hfe, 8'h03);
    chk("secured", 1, locked);
    unlock(KEY, 1'b1);
    boot(1'b0, 1'b1, 8'h00, 8'h81);
    chk("secured", 1, locked);
    test_done();
  end
endmodule
